// *** hw/cpsr_irq_gate.sv ***
// Interrupt request qualification for the status register block
`timescale 1ns/1ps
module cpsr_irq_gate
    import cpsr_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        pie_i,
    input  wire logic        set_irq_enable_i,
    input  wire logic [5:0]  crs_i,
    input  wire logic [5:0]  il_i,
    input  wire logic [31:0] pending_i,
    input  wire logic [31:0] enable_i,
    input  wire logic        ext_req_i,
    input  wire logic [5:0]  ext_level_i,
    input  wire logic [5:0]  ext_set_i,
    output logic             int_req_o,
    output logic             ext_ok_o
);

    logic nxt_int_req;
    logic nxt_ext_ok;

    // ------------------------------------------------------------
    // Qualification
    // ------------------------------------------------------------
    // Internal request needs the global enable and one enabled line
    assign nxt_int_req = pie_i && |(pending_i & enable_i);
    // Level must strictly exceed the threshold; a request for the set in
    // use is also held off while the set enable is low
    assign nxt_ext_ok  = ext_req_i && pie_i
                       && (ext_level_i > il_i)
                       && (set_irq_enable_i || ext_set_i != crs_i);

    // Registered so the core sees a clean level
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            int_req_o <= 1'b0;
            ext_ok_o  <= 1'b0;
        end else begin
            int_req_o <= nxt_int_req;
            ext_ok_o  <= nxt_ext_ok;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_ext_level_strict: assert property (
        (ext_req_i && ext_level_i <= il_i) |=> !ext_ok_o)
        else $error("External interrupt accepted at or below threshold");
    a_int_needs_pie: assert property (
        !pie_i |=> !int_req_o && !ext_ok_o)
        else $error("Interrupt request while global enable is low");
    a_int_req_and: assert property (
        (pie_i && (pending_i & enable_i) != 32'h0) |=> int_req_o)
        else $error("Enabled pending line did not raise a request");

endmodule

// *** hw/cpsr_pkg.sv ***
// Shared constants and types for the processor status and interrupt registers
package cpsr_pkg;

    // ----------------------------------------------------------------
    // Build options
    // ----------------------------------------------------------------
    localparam int         CPSR_NUM_SETS   = 4;   // Normal set plus shadows
    localparam int         CPSR_SET_BITS   = 2;   // Bits needed for sets-1
    localparam logic       CPSR_HAS_MMU    = 1'b1;
    localparam logic       CPSR_HAS_IIC    = 1'b1; // Internal irq controller
    localparam logic       CPSR_HAS_EIC    = 1'b1; // External irq interface
    localparam logic       CPSR_HAS_SHADOW = 1'b1;

    // ----------------------------------------------------------------
    // Control register indices
    // ----------------------------------------------------------------
    localparam logic [4:0] CPSR_IDX_STATUS  = 5'h00;
    localparam logic [4:0] CPSR_IDX_ESAVED  = 5'h01;
    localparam logic [4:0] CPSR_IDX_BSAVED  = 5'h02;
    localparam logic [4:0] CPSR_IDX_IRQ_EN  = 5'h03;
    localparam logic [4:0] CPSR_IDX_IRQ_PND = 5'h04;

    // ----------------------------------------------------------------
    // Widths and reset values
    // ----------------------------------------------------------------
    localparam int          CPSR_FLD_W      = 6;
    localparam int          CPSR_IRQ_LINES  = 32;
    localparam logic [5:0]  CPSR_SET_ZERO   = 6'h00;
    localparam logic [5:0]  CPSR_SET_MASK   = 6'h03; // Implemented set bits
    localparam logic [31:0] CPSR_WORD_ZERO  = 32'h0000_0000;

    // Status word layout, bit 31 down to bit 0
    typedef struct packed {
        logic [7:0] rsvd;       // Reads zero
        logic       set_irq_enable;
        logic       nmi_mode;
        logic [5:0] previous_set_index;
        logic [5:0] current_set_index;
        logic [5:0] interrupt_level_threshold;
        logic       handler_active_flag;
        logic       exception_active_flag;
        logic       privilege_level_bit;
        logic       global_irq_enable;
    } cpsr_status_s;

    // Status word after reset: all zero except the set enable
    localparam cpsr_status_s CPSR_STATUS_RST = '{
        rsvd: 8'h00, set_irq_enable: 1'b1, nmi_mode: 1'b0,
        previous_set_index: 6'h00, current_set_index: 6'h00,
        interrupt_level_threshold: 6'h00, handler_active_flag: 1'b0,
        exception_active_flag: 1'b0, privilege_level_bit: 1'b0,
        global_irq_enable: 1'b0};

    // Kinds of event that enter the status logic
    typedef enum logic [2:0] {
        CPSR_EV_NONE,
        CPSR_EV_EXC,     // Exception that is not an interrupt
        CPSR_EV_INT_IRQ, // Internal interrupt taken
        CPSR_EV_EXT_IRQ, // External interrupt taken
        CPSR_EV_BREAK
    } cpsr_event_e;

    // One event request from the pipeline
    typedef struct packed {
        cpsr_event_e kind;
        logic [5:0]  req_set;   // Set asked for by an external interrupt
    } cpsr_event_s;

    // Control register access from the instruction path
    typedef struct packed {
        logic        wr_en;
        logic        rd_en;
        logic [4:0]  idx;
        logic [31:0] wdata;
    } cpsr_ctl_s;

endpackage

// *** hw/cpsr_status_regs.sv ***
// Processor status word, saved copies and interrupt mask registers
`timescale 1ns/1ps
//
// Contract
// - current_set_index shows active set; zero is normal, others shadow.
// - Exceptions that are not interrupts force current_set_index to zero.
// - Software writes never change current_set_index.
// - Unused high set-index bits read zero; software writes them zero.
// - External maskable interrupt served only when level exceeds threshold.
// - Taking an external interrupt sets handler_active_flag.
// - Any exception sets exception_active_flag; software clears it.
// - Exception flag serves the MMU miss check; reads zero without MMU.
// - Privilege bit one means user mode; zero without MMU.
// - Global enable low ignores interrupts, never other exceptions.
// - Unimplemented fields read zero, set enable reads one.
// - Interrupt with exception flag clear saves status to exception copy.
// - Interrupt asking for a shadow set saves into shadow copy instead.
// - Exception return restores from saved copy chosen by current set.
// - Exception copy is fully read/write and resets to zero.
// - Break saves status to break copy; break return restores it.
// - Break copy is fully read/write and resets to zero.
// - Each mask bit enables its matching one of 32 interrupt lines.
// - Mask reads zero when no internal interrupt controller exists.
// - Pending view mirrors interrupt lines; writes have no effect.
// - After any save, current set index is copied to previous index.
module cpsr_status_regs
    import cpsr_pkg::*;
(
    input  wire logic         core_clk_i,
    input  wire logic         sys_rst_i,
    input  wire cpsr_ctl_s    ctl_i,
    input  wire cpsr_event_s  event_i,
    input  wire logic         eret_i,
    input  wire logic         bret_i,
    input  wire logic [31:0]  irq_line_i,
    input  wire logic         ext_req_i,
    input  wire logic [5:0]   ext_level_i,
    input  wire logic [5:0]   ext_set_i,
    output cpsr_status_s      status_o,
    output logic [31:0]       rd_data_o,
    output logic              rd_valid_o,
    output logic              int_req_o,
    output logic              ext_ok_o
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    cpsr_status_s status_ff;
    cpsr_status_s nxt_status;
    logic [31:0]  esaved_ff;
    logic [31:0]  nxt_esaved;
    logic [31:0]  bsaved_ff;
    logic [31:0]  nxt_bsaved;
    logic [31:0]  ssaved_ff;     // Shadow copy, hardware only
    logic [31:0]  nxt_ssaved;
    logic [31:0]  irq_mask_ff;
    logic [31:0]  irq_pend_ff;
    logic [31:0]  rd_data_ff;
    logic         rd_valid_ff;
    logic [31:0]  nxt_rd_data;
    logic         is_irq;
    logic         to_shadow;
    logic         save_exc;
    logic         wr_status;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Clean a word before it lands in the live status: unused bits of
    // the set fields and options not built are forced to their idle value
    function automatic cpsr_status_s clean_status(input logic [31:0] w);
        cpsr_status_s s;
        s = cpsr_status_s'(w);
        s.rsvd = 8'h00;
        s.previous_set_index = s.previous_set_index & CPSR_SET_MASK;
        s.current_set_index  = s.current_set_index & CPSR_SET_MASK;
        if (!CPSR_HAS_MMU) begin
            s.exception_active_flag = 1'b0;
            s.privilege_level_bit   = 1'b0;
        end
        if (!CPSR_HAS_EIC) begin
            s.interrupt_level_threshold = CPSR_SET_ZERO;
            s.handler_active_flag       = 1'b0;
            s.nmi_mode                  = 1'b0;
        end
        if (!CPSR_HAS_EIC || !CPSR_HAS_SHADOW) begin
            s.set_irq_enable = 1'b1;
        end
        if (!CPSR_HAS_SHADOW) begin
            s.previous_set_index = CPSR_SET_ZERO;
            s.current_set_index  = CPSR_SET_ZERO;
        end
        return s;
    endfunction

    // Index match for a write from the instruction path
    function automatic logic wr_hit(input cpsr_ctl_s c,
                                    input logic [4:0] idx);
        return c.wr_en && (c.idx == idx);
    endfunction

    // ------------------------------------------------------------
    // Event decode
    // ------------------------------------------------------------
    assign is_irq    = (event_i.kind == CPSR_EV_INT_IRQ)
                    || (event_i.kind == CPSR_EV_EXT_IRQ);
    // Only external interrupts may ask for a shadow set
    assign to_shadow = CPSR_HAS_SHADOW && (event_i.kind == CPSR_EV_EXT_IRQ)
                    && ((event_i.req_set & CPSR_SET_MASK) != CPSR_SET_ZERO);
    // A nested exception keeps the first saved copy intact
    assign save_exc  = ((event_i.kind == CPSR_EV_EXC) || is_irq)
                    && !to_shadow && !status_ff.exception_active_flag;
    assign wr_status = wr_hit(ctl_i, CPSR_IDX_STATUS);

    // ------------------------------------------------------------
    // Live status word
    // ------------------------------------------------------------
    // Priority: event taken, then the two returns, then software write.
    // The pipeline issues at most one of these per cycle.
    always_comb begin
        nxt_status = status_ff;
        unique case (event_i.kind)
            CPSR_EV_NONE: begin
                if (eret_i) begin
                    // Set zero means an ordinary exception was taken
                    if (status_ff.current_set_index == CPSR_SET_ZERO) begin
                        nxt_status = clean_status(esaved_ff);
                    end else begin
                        nxt_status = clean_status(ssaved_ff);
                    end
                end else if (bret_i) begin
                    nxt_status = clean_status(bsaved_ff);
                end else if (wr_status) begin
                    nxt_status = clean_status(ctl_i.wdata);
                    // Set index is kept by hardware only
                    nxt_status.current_set_index =
                        status_ff.current_set_index;
                end
            end
            CPSR_EV_EXC, CPSR_EV_BREAK: begin
                nxt_status.previous_set_index =
                    status_ff.current_set_index;
                nxt_status.current_set_index = CPSR_SET_ZERO;
                nxt_status.exception_active_flag = CPSR_HAS_MMU;
                nxt_status.privilege_level_bit   = 1'b0;
                nxt_status.global_irq_enable     = 1'b0;
            end
            CPSR_EV_INT_IRQ, CPSR_EV_EXT_IRQ: begin
                nxt_status.previous_set_index =
                    status_ff.current_set_index;
                if (to_shadow) begin
                    nxt_status.current_set_index =
                        event_i.req_set & CPSR_SET_MASK;
                end
                if (event_i.kind == CPSR_EV_EXT_IRQ) begin
                    nxt_status.handler_active_flag = CPSR_HAS_EIC;
                end
                nxt_status.exception_active_flag = CPSR_HAS_MMU;
                nxt_status.privilege_level_bit   = 1'b0;
                nxt_status.global_irq_enable     = 1'b0;
            end
            default: begin
                nxt_status = status_ff;
            end
        endcase
    end

    // Status register
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            status_ff <= CPSR_STATUS_RST;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // ------------------------------------------------------------
    // Saved copies
    // ------------------------------------------------------------
    // Hardware save wins over a software write in the same cycle
    always_comb begin
        nxt_esaved = esaved_ff;
        nxt_bsaved = bsaved_ff;
        nxt_ssaved = ssaved_ff;
        if (save_exc) begin
            nxt_esaved = status_ff;
        end else if (wr_hit(ctl_i, CPSR_IDX_ESAVED)) begin
            nxt_esaved = ctl_i.wdata;
        end
        if (event_i.kind == CPSR_EV_BREAK) begin
            nxt_bsaved = status_ff;
        end else if (wr_hit(ctl_i, CPSR_IDX_BSAVED)) begin
            nxt_bsaved = ctl_i.wdata;
        end
        if (to_shadow) begin
            nxt_ssaved = status_ff;
        end
    end

    // Copies reset to zero
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            esaved_ff <= CPSR_WORD_ZERO;
            bsaved_ff <= CPSR_WORD_ZERO;
            ssaved_ff <= CPSR_WORD_ZERO;
        end else begin
            esaved_ff <= nxt_esaved;
            bsaved_ff <= nxt_bsaved;
            ssaved_ff <= nxt_ssaved;
        end
    end

    // ------------------------------------------------------------
    // Interrupt mask and pending view
    // ------------------------------------------------------------
    // Mask stays zero when the internal controller is left out
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_mask_ff <= CPSR_WORD_ZERO;
        end else if (CPSR_HAS_IIC && wr_hit(ctl_i, CPSR_IDX_IRQ_EN)) begin
            irq_mask_ff <= ctl_i.wdata;
        end
    end

    // Lines are sampled each cycle; writes to the view are dropped
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_pend_ff <= CPSR_WORD_ZERO;
        end else if (CPSR_HAS_IIC) begin
            irq_pend_ff <= irq_line_i;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // One cycle read latency; unknown indices return zero
    always_comb begin
        nxt_rd_data = CPSR_WORD_ZERO;
        unique case (ctl_i.idx)
            CPSR_IDX_STATUS:  nxt_rd_data = status_ff;
            CPSR_IDX_ESAVED:  nxt_rd_data = esaved_ff;
            CPSR_IDX_BSAVED:  nxt_rd_data = bsaved_ff;
            CPSR_IDX_IRQ_EN:  nxt_rd_data = irq_mask_ff;
            CPSR_IDX_IRQ_PND: nxt_rd_data = irq_pend_ff;
            default:          nxt_rd_data = CPSR_WORD_ZERO;
        endcase
    end

    // Read data register
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_data_ff  <= CPSR_WORD_ZERO;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= ctl_i.rd_en;
            if (ctl_i.rd_en) begin
                rd_data_ff <= nxt_rd_data;
            end
        end
    end

    assign status_o   = status_ff;
    assign rd_data_o  = rd_data_ff;
    assign rd_valid_o = rd_valid_ff;

    // ------------------------------------------------------------
    // Interrupt qualification
    // ------------------------------------------------------------
    cpsr_irq_gate u_gate (
        .core_clk_i  (core_clk_i),
        .sys_rst_i   (sys_rst_i),
        .pie_i       (status_ff.global_irq_enable),
        .set_irq_enable_i      (status_ff.set_irq_enable),
        .crs_i       (status_ff.current_set_index),
        .il_i        (status_ff.interrupt_level_threshold),
        .pending_i   (irq_pend_ff),
        .enable_i    (irq_mask_ff),
        .ext_req_i   (ext_req_i),
        .ext_level_i (ext_level_i),
        .ext_set_i   (ext_set_i),
        .int_req_o   (int_req_o),
        .ext_ok_o    (ext_ok_o)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_exc_taken;
        event_i.kind == CPSR_EV_EXC;
    endsequence

    sequence s_irq_saved;
        is_irq && !to_shadow && !status_ff.exception_active_flag;
    endsequence

    a_exc_zero_set: assert property (
        s_exc_taken |=> status_ff.current_set_index == CPSR_SET_ZERO)
        else $error("Exception left a shadow set active");
    a_sw_keeps_crs: assert property (
        (wr_status && event_i.kind == CPSR_EV_NONE && !eret_i && !bret_i)
        |=> $stable(status_ff.current_set_index))
        else $error("Software write changed current set");
    a_set_high_zero: assert property (
        (status_ff.current_set_index & ~CPSR_SET_MASK) == CPSR_SET_ZERO)
        else $error("Unused set index bits are set");
    a_ext_sets_ih: assert property (
        event_i.kind == CPSR_EV_EXT_IRQ |=> status_ff.handler_active_flag)
        else $error("Handler flag not set on external interrupt");
    a_eh_on_event: assert property (
        event_i.kind != CPSR_EV_NONE |=> status_ff.exception_active_flag)
        else $error("Exception flag not set on exception");
    a_irq_saves_copy: assert property (
        s_irq_saved |=> esaved_ff == $past(status_ff))
        else $error("Status not saved on interrupt");
    a_eret_restore: assert property (
        (eret_i && event_i.kind == CPSR_EV_NONE
         && status_ff.current_set_index == CPSR_SET_ZERO)
        |=> status_ff == clean_status($past(esaved_ff)))
        else $error("Exception return did not restore status");
    a_break_cycle: assert property (
        event_i.kind == CPSR_EV_BREAK
        |=> bsaved_ff == $past(status_ff))
        else $error("Break did not save status");
    a_prs_copy: assert property (
        event_i.kind != CPSR_EV_NONE
        |=> status_ff.previous_set_index
            == $past(status_ff.current_set_index))
        else $error("Previous set index not updated");
    a_pend_mirror: assert property (
        ##1 irq_pend_ff == $past(irq_line_i))
        else $error("Pending view does not track lines");

endmodule

// *** verification/cpsr_irq_src.sv ***
// Peripheral side model: interrupt lines and external requests
`timescale 1ns/1ps
module cpsr_irq_src
    import cpsr_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic [31:0] pat_i,
    output logic [31:0]      irq_line_o,
    output logic             ext_req_o,
    output logic [5:0]       ext_level_o,
    output logic [5:0]       ext_set_o
);
    // Quiet lines at time zero so the core never sees unknowns
    initial begin
        irq_line_o = 32'h0000_0000;
        ext_req_o = 1'b0;
        ext_level_o = 6'h00;
        ext_set_o = 6'h00;
    end
    // Change off the sampling edge, as a synchronous source would
    always @(negedge core_clk_i) begin
        irq_line_o <= pat_i;
        ext_req_o <= 1'($urandom_range(1, 0));
        ext_level_o <= 6'($urandom_range(63, 0));
        // Only implemented set numbers are ever asked for
        ext_set_o <= 6'($urandom_range(CPSR_NUM_SETS - 1, 0));
    end
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the status and interrupt registers
`timescale 1ns/1ps
module tb
    import cpsr_pkg::*;
;
    logic         core_clk, sys_rst, eret, bret, ext_req;
    logic         rd_valid, int_req, ext_ok;
    logic [31:0]  irq_line, rd_data, irq_pat, rnd;
    logic [5:0]   ext_level, ext_set;
    cpsr_ctl_s    ctl;
    cpsr_event_s  ev;
    cpsr_status_s status;
    logic [31:0]  exp_q[$];
    logic [33:0]  lvl_q[$], lvl_x;
    logic [31:0]  line_q;
    logic         watch;
    int           err_count, check_count, cycles;

    cpsr_status_regs dut (.core_clk_i(core_clk), .sys_rst_i(sys_rst),
        .ctl_i(ctl), .event_i(ev), .eret_i(eret), .bret_i(bret),
        .irq_line_i(irq_line), .ext_req_i(ext_req),
        .ext_level_i(ext_level), .ext_set_i(ext_set), .status_o(status),
        .rd_data_o(rd_data), .rd_valid_o(rd_valid), .int_req_o(int_req),
        .ext_ok_o(ext_ok));
    cpsr_irq_src src (.core_clk_i(core_clk), .pat_i(irq_pat),
        .irq_line_o(irq_line), .ext_req_o(ext_req),
        .ext_level_o(ext_level), .ext_set_o(ext_set));

    // ------------------------------------------------------------
    // Drivers: every call sets all inputs, so none is set twice
    // ------------------------------------------------------------
    task automatic op(input cpsr_ctl_s c, input cpsr_event_s e,
                      input logic er, input logic br);
        ctl <= c;
        ev <= e;
        eret <= er;
        bret <= br;
        @(negedge core_clk);
    endtask
    task automatic wr(input logic [4:0] i, input logic [31:0] d);
        op('{1'b1, 1'b0, i, d}, '0, 1'b0, 1'b0);
    endtask
    // Expected value is noted before the request goes out
    task automatic rd(input logic [4:0] i, input logic [31:0] x);
        exp_q.push_back(x);
        op('{1'b0, 1'b1, i, 32'h0000_0000}, '0, 1'b0, 1'b0);
    endtask
    task automatic evt(input cpsr_event_e k, input logic [5:0] s);
        op('0, '{k, s}, 1'b0, 1'b0);
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_lvl(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        // Notes never matched by a result count as misses
        err_count += exp_q.size() + lvl_q.size();
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Monitor: read data is settled by the falling edge
    always @(negedge core_clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("[FAIL] t=%0t got=%h exp=none", $time, rd_data);
            end else begin
                cmp(rd_data, exp_q.pop_front());
            end
        end
    end
    // Live word and request levels: noted at the edge that registers
    // them, checked half a cycle later while they stand. Global enable
    // is 1, threshold 5 and set enable 1 inside the watch window.
    always @(posedge core_clk) begin
        if (watch) begin
            lvl_q.push_back({32'h0083_0051, |(line_q & rnd),
                             ext_req && ext_level > 6'h05});
        end
        line_q <= irq_line; // Pending view lags the lines by one edge
    end
    always @(negedge core_clk) begin
        if (lvl_q.size() != 0) begin
            lvl_x = lvl_q.pop_front();
            cmp(status, lvl_x[33:2]);
            cmp_lvl(int_req, lvl_x[1]);
            cmp_lvl(ext_ok, lvl_x[0]);
        end
    end
    // Hang guard, well above the roughly 53 cycles of the run
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            finish_test();
        end
    end
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    initial begin
        {sys_rst, eret, bret} = 3'h4;
        ctl = '0;
        ev = '0;
        irq_pat = 32'h0000_0000;
        {cycles, err_count, check_count} = '0;
        watch = 1'b0;
        void'($urandom(9021));
        repeat (6) @(negedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        rd(5'h00, 32'h0080_0000);
        rd(5'h01, 32'h0000_0000);
        rd(5'h02, 32'h0000_0000);
        rd(5'h05, 32'h0000_0000);
        // Only implemented set numbers; the read-only current set gets 1
        wr(5'h00, 32'h0083_0451);
        rd(5'h00, 32'h0083_0051);
        rnd = $urandom();
        irq_pat <= $urandom();
        wr(5'h03, rnd);
        watch = 1'b1;
        rd(5'h03, rnd);
        wr(5'h04, ~irq_pat);
        rd(5'h04, irq_pat);
        watch = 1'b0;
        evt(CPSR_EV_EXC, 6'h00);
        rd(5'h00, 32'h0080_0054);
        rd(5'h01, 32'h0083_0051);
        op('0, '0, 1'b1, 1'b0);
        rd(5'h00, 32'h0083_0051);
        evt(CPSR_EV_BREAK, 6'h00);
        rd(5'h00, 32'h0080_0054);
        rd(5'h02, 32'h0083_0051);
        op('0, '0, 1'b0, 1'b1);
        rd(5'h00, 32'h0083_0051);
        wr(5'h01, 32'h0000_0030);
        evt(CPSR_EV_EXT_IRQ, 6'h02);
        rd(5'h00, 32'h0080_085c);
        rd(5'h01, 32'h0000_0030);
        op('0, '0, 1'b1, 1'b0);
        rd(5'h00, 32'h0083_0051);
        // Saved copies hold any pattern within their defined fields
        for (int i = 0; i < 4; i++) begin
            rnd = $urandom() & 32'h00c3_0fff;
            wr(5'h01, rnd);
            wr(5'h02, ~rnd & 32'h00c3_0fff);
            rd(5'h01, rnd);
            rd(5'h02, ~rnd & 32'h00c3_0fff);
        end
        repeat (4) op('0, '0, 1'b0, 1'b0);
        finish_test();
    end
endmodule
